//--- tdc_pkg.sv
package tdc_pkg;

  // ==========================================================
  // Register map, 8-bit I/O addresses, 4-bit data
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'hc5;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hd2;
  localparam logic [7:0] ADDR_PORT_DATA = 8'hd3;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'hd8;
  localparam logic [7:0] ADDR_MODE_CFG = 8'he0;
  localparam logic [7:0] ADDR_PAUSE_SEL = 8'he1;
  localparam logic [7:0] ADDR_FLASH_SEL = 8'he2;
  localparam logic [7:0] ADDR_LINE_CTRL = 8'he3;
  localparam logic [7:0] ADDR_HANDSFREE = 8'he4;
  localparam logic [7:0] ADDR_GAP_SEL = 8'he5;
  localparam logic [7:0] ADDR_TONE_EN = 8'he6;
  localparam logic [7:0] ADDR_DIAL_CODE = 8'he7;
  localparam logic [7:0] ADDR_MUTE_CTRL = 8'he8;
  localparam logic [7:0] ADDR_HOOK_CTRL = 8'he9;
  localparam logic [7:0] ADDR_OUT_SELECT = 8'hea;

  // ==========================================================
  // Field positions
  localparam int BIT_PULSE_MODE = 3;
  localparam int BIT_MAKE_BREAK = 1;
  localparam int BIT_PULSE_RATE = 0;
  localparam int BIT_HOLD = 2;
  localparam int BIT_PAUSE = 1;
  localparam int BIT_FLASH = 0;
  localparam int BIT_HANDSFREE = 3;
  localparam int BIT_ROW_TONE = 1;
  localparam int BIT_COL_TONE = 0;
  localparam int BIT_RX_SILENCE = 1;
  localparam int BIT_TX_SILENCE = 0;
  localparam int BIT_KEEP_SEL = 2;
  localparam int BIT_HF_SEL = 3;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_OSC3_ON = 0;

  // ==========================================================
  // Reset values
  localparam logic [3:0] RST_PAUSE_CODE = 4'h4;
  localparam logic [3:0] RST_FLASH_CODE = 4'h6;
  localparam logic [3:0] RST_GAP_CODE = 4'h8;

  // ==========================================================
  // Timing: all intervals count ticks of the 32768 Hz time base
  localparam int CLK_HZ = 10000000;
  localparam int OSC_HZ = 32768;
  localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;
  localparam logic [18:0] STEP_TICKS = 19'h00c00;        // 93.75 ms
  localparam logic [18:0] SEC_TICKS = 19'h08000;         // 1 s
  localparam logic [18:0] FLASH_GAP_TICKS = 19'h07800;   // 10 steps, 938 ms
  localparam logic [18:0] TONE_TICKS = 19'h00c00;        // 94 ms
  localparam logic [18:0] TONE_GAP_TICKS = 19'h00c00;    // 94 ms
  localparam logic [7:0] MUTE_HOLD_TICKS = 8'h84;        // 4 ms
  // Make / break lengths per pulse: 10 pps = 100 ms, 20 pps = 50 ms
  localparam logic [18:0] MAKE_10_40 = 19'h0051f;
  localparam logic [18:0] BREAK_10_40 = 19'h007ad;
  localparam logic [18:0] MAKE_10_33 = 19'h00444;
  localparam logic [18:0] BREAK_10_33 = 19'h00888;
  localparam logic [18:0] MAKE_20_40 = 19'h0028f;
  localparam logic [18:0] BREAK_20_40 = 19'h003d7;
  localparam logic [18:0] MAKE_20_33 = 19'h00222;
  localparam logic [18:0] BREAK_20_33 = 19'h00444;

  // ==========================================================
  // Sequencer states
  typedef enum logic [8:0] {
    TDC_IDLE = 9'h001,
    TDC_TONE = 9'h002,
    TDC_TONE_GAP = 9'h004,
    TDC_MAKE = 9'h008,
    TDC_BREAK = 9'h010,
    TDC_DIGIT_GAP = 9'h020,
    TDC_PAUSE = 9'h040,
    TDC_FLASH = 9'h080,
    TDC_FLASH_GAP = 9'h100
  } tdc_state_type;

  // ==========================================================
  // Processor access port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] wdata;
  } tdc_bus_type;

  // Line-side pins
  typedef struct packed {
    logic dial_pulse_out_n;
    logic receive_silence_n;
    logic transmit_silence_n;
    logic tone_active;
    logic row_tone_allow;
    logic column_tone_allow;
    logic [3:0] port_out;
  } tdc_line_type;

endpackage : tdc_pkg

//--- tdc_dial_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// R1: Flash holds dial pulse pin low throughout.
// R2: Flash mutes receive and transmit, plus pause.
// R3: Fixed 938 ms pause after flash time.
// R4: Line-hold bit is a plain on/off level.
// R5: Pin twelve carries hold only when selected.
// R6: Selected pin twelve follows line-hold bit.
// R7: Hold on mutes transmit, raises hold output.
// R8: Only dial, pause, flash completion interrupt.
// R9: Tone interrupt after tone plus 94 ms.
// R10: Pulse interrupt after pulses plus gap.
// R11: Pause waits N seconds then interrupts.
// R12: Flash waits selected time then interrupts.
// R13: Interrupt flag readable, cleared by reading.
// R14: Software clears flag before next cycle.
// R15: Mask bit gates request, resets zero.
// R16: Mode, ratio, rate bits; reset zero.
// R17: Pause code N seconds, reset four.
// R18: Flash code in 94 ms steps, reset 563.
// R19: Gap code 94 ms steps, reset 750.
// R20: Row and column tone enables reset one.
// R21: Dial code write starts cycle, N pulses.
// R22: Flash end interrupts and clears trigger.
// R23: Intervals count prescaled 32768 Hz ticks.
// R24: Unused bits read zero, ignore writes.
module tdc_dial_ctrl
  import tdc_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire tdc_bus_type bus,
  output logic [3:0] rdata,
  output logic dial_irq_request,
  output logic cpu_clock_source,
  output logic osc3_enable,
  output logic off_hook_ctrl,
  output tdc_line_type line
);

  // ==========================================================
  // State
  typedef struct packed {
    tdc_state_type state;
    logic [18:0] cnt;
    logic [3:0] pulses;
    logic [7:0] mhold;
    logic mhold_rx;
    logic [8:0] div;
    logic tick;
    logic dial_irq_pending;
    logic dial_irq_allow;
    logic [3:0] port;
    logic cpu_clock_source;
    logic osc3_on;
    logic pulse_mode_select;
    logic make_break_select;
    logic pulse_rate_select;
    logic [3:0] pause_length_code;
    logic [3:0] flash_length_code;
    logic line_hold;
    logic pause_go;
    logic flash_go;
    logic handsfree_on;
    logic [3:0] interdigit_gap_code;
    logic row_tone_allow;
    logic column_tone_allow;
    logic [3:0] dial_digit_code;
    logic receive_silence_ctrl;
    logic transmit_silence_ctrl;
    logic off_hook;
    logic line_keep_output_select;
    logic handsfree_output_select;
    logic [3:0] rdata;
  } tdc_regs_type;

  tdc_regs_type s_q;
  tdc_regs_type s_d;

  function automatic logic [18:0] scaled(input logic [18:0] unit, input logic [3:0] code);
    logic [22:0] prod;
    prod = 23'(unit) * 23'(code);
    return prod[18:0] - 19'h00001;
  endfunction : scaled

  logic [18:0] make_len;
  logic [18:0] break_len;
  logic done;
  logic cycle_end;
  logic wr_hit;
  logic idle;
  logic seq_tx_mute;
  logic seq_rx_mute;

  // ==========================================================
  // Pulse timing
  // Lengths load one short: the tick that finds zero ends the state
  always_comb begin
    unique case ({s_q.pulse_rate_select, s_q.make_break_select}) // R16
      2'b00: begin
        make_len = MAKE_10_40 - 19'h00001;
        break_len = BREAK_10_40 - 19'h00001;
      end
      2'b01: begin
        make_len = MAKE_10_33 - 19'h00001;
        break_len = BREAK_10_33 - 19'h00001;
      end
      2'b10: begin
        make_len = MAKE_20_40 - 19'h00001;
        break_len = BREAK_20_40 - 19'h00001;
      end
      2'b11: begin
        make_len = MAKE_20_33 - 19'h00001;
        break_len = BREAK_20_33 - 19'h00001;
      end
    endcase
  end

  // Tick phase is free, so a fresh interval may run up to one tick short
  assign done = s_q.tick && (s_q.cnt == 19'h00000);
  assign idle = (s_q.state == TDC_IDLE);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    cycle_end = 1'b0;
    wr_hit = bus.wr;
    s_d.tick = 1'b0;
    // ==========================================================
    // Time base: one-cycle enable at about 32768 Hz
    if (s_q.div == 9'(OSC_DIV - 1)) begin // R23
      s_d.div = 9'h000;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 9'h001;
    end
    if (s_q.tick && !idle && s_q.cnt != 19'h00000) begin
      s_d.cnt = s_q.cnt - 19'h00001;
    end
    if (s_q.tick && s_q.mhold != 8'h00) begin
      s_d.mhold = s_q.mhold - 8'h01;
    end

    // ==========================================================
    // Sequencer
    unique case (s_q.state)
      TDC_IDLE: begin
        if (s_q.flash_go) begin
          s_d.state = TDC_FLASH;
          s_d.cnt = scaled(STEP_TICKS, s_q.flash_length_code); // R12 R18 R23
        end else if (s_q.pause_go) begin
          s_d.state = TDC_PAUSE;
          s_d.cnt = scaled(SEC_TICKS, s_q.pause_length_code); // R11 R17
        end
      end
      TDC_TONE: begin
        if (done) begin
          s_d.state = TDC_TONE_GAP;
          s_d.cnt = TONE_GAP_TICKS - 19'h00001; // R9
        end
      end
      TDC_TONE_GAP: begin
        if (done) begin
          s_d.state = TDC_IDLE;
          cycle_end = 1'b1; // R9
          s_d.mhold = MUTE_HOLD_TICKS;
          s_d.mhold_rx = 1'b0;
        end
      end
      TDC_MAKE: begin
        if (done) begin
          s_d.state = TDC_BREAK;
          s_d.cnt = break_len;
        end
      end
      TDC_BREAK: begin
        if (done) begin
          if (s_q.pulses == 4'h1) begin
            s_d.state = TDC_DIGIT_GAP;
            s_d.cnt = scaled(STEP_TICKS, s_q.interdigit_gap_code); // R19
          end else begin
            s_d.state = TDC_MAKE;
            s_d.cnt = make_len;
            s_d.pulses = s_q.pulses - 4'h1; // R21
          end
        end
      end
      TDC_DIGIT_GAP: begin
        if (done) begin
          s_d.state = TDC_IDLE;
          cycle_end = 1'b1; // R10
          s_d.mhold = MUTE_HOLD_TICKS;
          s_d.mhold_rx = 1'b1;
        end
      end
      TDC_PAUSE: begin
        if (done) begin
          s_d.state = TDC_IDLE;
          s_d.pause_go = 1'b0;
          cycle_end = 1'b1; // R11
        end
      end
      TDC_FLASH: begin
        if (done) begin
          s_d.state = TDC_FLASH_GAP;
          s_d.cnt = FLASH_GAP_TICKS - 19'h00001; // R3
        end
      end
      TDC_FLASH_GAP: begin
        if (done) begin
          s_d.state = TDC_IDLE;
          s_d.flash_go = 1'b0; // R22
          cycle_end = 1'b1; // R22
        end
      end
      default: begin
        s_d.state = TDC_IDLE;
      end
    endcase

    // ==========================================================
    // Register writes; unused bits are simply not stored
    if (wr_hit) begin
      unique case (bus.addr)
        ADDR_IRQ_MASK: s_d.dial_irq_allow = bus.wdata[0]; // R15 R24
        ADDR_PORT_DATA: s_d.port = bus.wdata;
        ADDR_OSC_CTRL: begin
          s_d.cpu_clock_source = bus.wdata[BIT_CLK_SRC];
          s_d.osc3_on = bus.wdata[BIT_OSC3_ON];
        end
        ADDR_MODE_CFG: begin
          s_d.pulse_mode_select = bus.wdata[BIT_PULSE_MODE]; // R16
          s_d.make_break_select = bus.wdata[BIT_MAKE_BREAK];
          s_d.pulse_rate_select = bus.wdata[BIT_PULSE_RATE];
        end
        ADDR_PAUSE_SEL: s_d.pause_length_code = bus.wdata; // R17
        ADDR_FLASH_SEL: s_d.flash_length_code = bus.wdata; // R18
        ADDR_LINE_CTRL: begin
          s_d.line_hold = bus.wdata[BIT_HOLD]; // R4
          // A trigger while a cycle runs is dropped, not queued
          if (idle && !s_q.flash_go && !s_q.pause_go) begin
            s_d.flash_go = bus.wdata[BIT_FLASH];
            s_d.pause_go = bus.wdata[BIT_PAUSE] && !bus.wdata[BIT_FLASH];
          end
        end
        ADDR_HANDSFREE: s_d.handsfree_on = bus.wdata[BIT_HANDSFREE];
        ADDR_GAP_SEL: s_d.interdigit_gap_code = bus.wdata; // R19
        ADDR_TONE_EN: begin
          s_d.row_tone_allow = bus.wdata[BIT_ROW_TONE]; // R20
          s_d.column_tone_allow = bus.wdata[BIT_COL_TONE];
        end
        ADDR_DIAL_CODE: begin
          s_d.dial_digit_code = bus.wdata; // R21
          // Code zero wraps to sixteen pulses; software must never write it
          if (idle && !s_q.flash_go && !s_q.pause_go) begin
            if (s_q.pulse_mode_select) begin
              s_d.state = TDC_MAKE; // R21
              s_d.cnt = make_len;
              s_d.pulses = bus.wdata;
            end else begin
              s_d.state = TDC_TONE;
              s_d.cnt = TONE_TICKS - 19'h00001; // R9
            end
          end
        end
        ADDR_MUTE_CTRL: begin
          s_d.receive_silence_ctrl = bus.wdata[BIT_RX_SILENCE];
          s_d.transmit_silence_ctrl = bus.wdata[BIT_TX_SILENCE];
        end
        ADDR_HOOK_CTRL: s_d.off_hook = bus.wdata[0];
        ADDR_OUT_SELECT: begin
          s_d.line_keep_output_select = bus.wdata[BIT_KEEP_SEL]; // R5
          s_d.handsfree_output_select = bus.wdata[BIT_HF_SEL];
        end
        default: begin
        end
      endcase
    end

    // ==========================================================
    // Read data, registered; unmapped and unused bits read zero
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_IRQ_FLAG: s_d.rdata = {3'h0, s_q.dial_irq_pending}; // R13 R24
        ADDR_IRQ_MASK: s_d.rdata = {3'h0, s_q.dial_irq_allow};
        ADDR_PORT_DATA: s_d.rdata = s_q.port;
        ADDR_OSC_CTRL: s_d.rdata = {2'h0, s_q.cpu_clock_source, s_q.osc3_on};
        ADDR_MODE_CFG: begin
          s_d.rdata = {s_q.pulse_mode_select, 1'b0, s_q.make_break_select,
                       s_q.pulse_rate_select};
        end
        ADDR_PAUSE_SEL: s_d.rdata = s_q.pause_length_code;
        ADDR_FLASH_SEL: s_d.rdata = s_q.flash_length_code;
        ADDR_LINE_CTRL: s_d.rdata = {1'b0, s_q.line_hold, 2'h0};
        ADDR_HANDSFREE: s_d.rdata = {s_q.handsfree_on, 3'h0};
        ADDR_GAP_SEL: s_d.rdata = s_q.interdigit_gap_code;
        ADDR_TONE_EN: s_d.rdata = {2'h0, s_q.row_tone_allow, s_q.column_tone_allow};
        ADDR_DIAL_CODE: s_d.rdata = s_q.dial_digit_code;
        ADDR_MUTE_CTRL: begin
          s_d.rdata = {2'h0, s_q.receive_silence_ctrl, s_q.transmit_silence_ctrl};
        end
        ADDR_HOOK_CTRL: s_d.rdata = {3'h0, s_q.off_hook};
        ADDR_OUT_SELECT: begin
          s_d.rdata = {s_q.handsfree_output_select, s_q.line_keep_output_select, 2'h0};
        end
        default: s_d.rdata = 4'h0;
      endcase
    end

    // ==========================================================
    // Flag: a completion in the reading cycle survives the clear
    if (bus.rd && bus.addr == ADDR_IRQ_FLAG) begin
      s_d.dial_irq_pending = 1'b0; // R13
    end
    if (cycle_end) begin
      s_d.dial_irq_pending = 1'b1; // R8 R13
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      // Later non-blocking writes override the blanket clear
      s_q.state <= TDC_IDLE;
      s_q.pause_length_code <= RST_PAUSE_CODE; // R17
      s_q.flash_length_code <= RST_FLASH_CODE; // R18
      s_q.interdigit_gap_code <= RST_GAP_CODE; // R19
      s_q.row_tone_allow <= 1'b1; // R20
      s_q.column_tone_allow <= 1'b1;
      s_q.receive_silence_ctrl <= 1'b1;
      s_q.transmit_silence_ctrl <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Line outputs
  // Mute control bits act as enables for automatic muting
  // Mute hold bridges digits sent within 4 ms, so the line stays muted
  // Tone dialing leaves the receive path open
  assign seq_rx_mute = (s_q.state inside {TDC_MAKE, TDC_BREAK, TDC_DIGIT_GAP,
                        TDC_FLASH, TDC_FLASH_GAP}) || (s_q.mhold != 8'h00 && s_q.mhold_rx);
  assign seq_tx_mute = seq_rx_mute || (s_q.state inside {TDC_TONE, TDC_TONE_GAP}) ||
                       s_q.mhold != 8'h00;

  assign rdata = s_q.rdata;
  assign dial_irq_request = s_q.dial_irq_pending && s_q.dial_irq_allow; // R15
  assign cpu_clock_source = s_q.cpu_clock_source;
  assign osc3_enable = s_q.osc3_on;
  assign off_hook_ctrl = s_q.off_hook;

  always_comb begin
    // Dial pin idles at the hook level, low while on hook
    line.dial_pulse_out_n = s_q.off_hook && (s_q.state != TDC_BREAK) &&
                            (s_q.state != TDC_FLASH); // R1
    line.receive_silence_n = !(seq_rx_mute && s_q.receive_silence_ctrl); // R2
    line.transmit_silence_n = !((seq_tx_mute && s_q.transmit_silence_ctrl) ||
                                s_q.line_hold); // R2 R7
    line.tone_active = s_q.state == TDC_TONE;
    line.row_tone_allow = s_q.row_tone_allow; // R20
    line.column_tone_allow = s_q.column_tone_allow;
    line.port_out = s_q.port;
    // Port data one forces the pin high regardless of selection
    line.port_out[2] = s_q.port[2] || (s_q.line_keep_output_select && s_q.line_hold); // R5 R6 R7
    line.port_out[3] = s_q.port[3] || (s_q.handsfree_output_select && s_q.handsfree_on);
  end

endmodule : tdc_dial_ctrl

//--- tdc_dial_props.sv
`timescale 1ns/10ps
module tdc_dial_props
  import tdc_pkg::*;
#(
  parameter int OSC_DIV = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire tdc_bus_type bus,
  input wire logic [3:0] rdata,
  input wire logic dial_irq_request,
  input wire logic off_hook_ctrl,
  input wire tdc_line_type line
);
  // ==========================================================
  // Helpers
  localparam int TONE_CYC = 3072 * OSC_DIV;
  logic [1:0] mute_en_q;
  logic [19:0] tone_len_q;

  // Auto-mute enables mirrored from bus writes, since the checker sees no registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mute_en_q <= 2'h3;
    end else if (bus.wr && bus.addr == ADDR_MUTE_CTRL) begin
      mute_en_q <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !line.tone_active) begin
      tone_len_q <= 20'h0;
    end else begin
      tone_len_q <= tone_len_q + 20'h1;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_vals_a: assert property ($fell(rst) |-> rdata == 4'h0 && !dial_irq_request
    && line.row_tone_allow && line.column_tone_allow && line.transmit_silence_n)
    else $error("bad state after reset");
  flag_read_a: assert property (bus.rd && bus.addr == ADDR_IRQ_FLAG
    && dial_irq_request |=> rdata == 4'h1) else $error("flag read not one");
  read_clear_a: assert property (bus.rd && bus.addr == ADDR_IRQ_FLAG
    && dial_irq_request |=> !dial_irq_request) else $error("flag not cleared by read");
  mask_block_a: assert property (bus.wr && bus.addr == ADDR_IRQ_MASK
    && !bus.wdata[0] |=> !dial_irq_request) else $error("masked request seen");
  unused_zero_a: assert property (bus.rd && bus.addr == ADDR_IRQ_MASK
    |=> rdata[3:1] == 3'h0) else $error("unused mask bits not zero");
  trig_read_a: assert property (bus.rd && bus.addr == ADDR_LINE_CTRL
    |=> rdata[1:0] == 2'h0 && !rdata[3]) else $error("trigger bits read back");
  hold_mute_a: assert property (bus.wr && bus.addr == ADDR_LINE_CTRL
    && bus.wdata[BIT_HOLD] |=> !line.transmit_silence_n) else $error("hold did not mute");
  flash_mute_a: assert property (!line.dial_pulse_out_n && off_hook_ctrl
    && mute_en_q == 2'h3 |-> !line.transmit_silence_n && !line.receive_silence_n)
    else $error("line opened without muting");
  tone_len_a: assert property ($fell(line.tone_active) |->
    tone_len_q >= TONE_CYC - 2 * OSC_DIV && tone_len_q <= TONE_CYC + 2 * OSC_DIV)
    else $error("tone duration off");

  flash_seen_c: cover property ($rose(line.dial_pulse_out_n) && !line.transmit_silence_n);
  irq_seen_c: cover property ($rose(dial_irq_request));
  tone_seen_c: cover property ($fell(line.tone_active));
endmodule : tdc_dial_props

bind tdc_dial_ctrl tdc_dial_props #(.OSC_DIV(OSC_DIV)) u_props (.clk(clk), .rst(rst),
  .bus(bus), .rdata(rdata), .dial_irq_request(dial_irq_request),
  .off_hook_ctrl(off_hook_ctrl), .line(line));

//--- tdc_line_model.sv
`timescale 1ns/10ps
module tdc_line_model
  import tdc_pkg::*;
(
  input wire logic clk,
  input wire tdc_line_type line,
  input wire logic off_hook_ctrl,
  input wire logic clear,
  output logic [7:0] pulse_count,
  output logic [19:0] break_len
);
  // ==========================================================
  // Loop break counter: the exchange counts opened-loop pulses
  logic [19:0] run_q;

  always_ff @(posedge clk) begin
    if (clear) begin
      pulse_count <= 8'h0;
      break_len <= 20'h0;
      run_q <= 20'h0;
    end else if (off_hook_ctrl && !line.dial_pulse_out_n) begin
      run_q <= run_q + 20'h1;
    end else begin
      if (run_q != 20'h0) begin
        pulse_count <= pulse_count + 8'h1;
        break_len <= run_q;
      end
      run_q <= 20'h0;
    end
  end
endmodule : tdc_line_model

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top
  import tdc_pkg::*;
;
  localparam int DIV = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clear = 1'b1;
  tdc_bus_type bus = '0;
  logic [3:0] rdata;
  logic irq;
  logic hook;
  logic clk_src;
  logic osc3_on;
  tdc_line_type line;
  logic [7:0] pulse_count;
  logic [19:0] break_len;
  int errors = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  tdc_dial_ctrl #(.OSC_DIV(DIV)) dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .dial_irq_request(irq), .cpu_clock_source(clk_src), .osc3_enable(osc3_on),
    .off_hook_ctrl(hook),
    .line(line));
  tdc_line_model u_line (.clk(clk), .line(line), .off_hook_ctrl(hook), .clear(clear),
    .pulse_count(pulse_count), .break_len(break_len));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic near(input int got, input int exp, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    bus.wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [3:0] exp);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
    @(posedge clk);
    #1;
    bus.rd = 1'b0;
    @(posedge clk);
    #1;
    check(20'(rdata), 20'(exp));
  endtask : rd

  // Counts edges until the interrupt request shows, bounded
  task automatic wait_irq(output int n, input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_irq

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] adr [13] = '{8'hc5, 8'hd2, 8'hd3, 8'hd8, 8'he0, 8'he1, 8'he2, 8'he3,
      8'he5, 8'he6, 8'he7, 8'he8, 8'hf0};
    logic [3:0] val [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h6, 4'h0, 4'h8, 4'h3,
      4'h0, 4'h3, 4'h0};
    for (int i = 0; i < 13; i++) begin
      rd(adr[i], val[i]);
    end
    check(20'({line.dial_pulse_out_n, line.receive_silence_n}), 20'h1);
    $display("reset values done");
  endtask : t_reset

  task automatic t_regs();
    wr(ADDR_MODE_CFG, 4'hf);
    rd(ADDR_MODE_CFG, 4'hb);
    wr(ADDR_MODE_CFG, 4'h0);
    wr(ADDR_TONE_EN, 4'h1);
    check(20'({line.row_tone_allow, line.column_tone_allow}), 20'h1);
    wr(ADDR_TONE_EN, 4'h3);
    wr(ADDR_OSC_CTRL, 4'hf);
    check(20'({clk_src, osc3_on}), 20'h3);
    rd(ADDR_OSC_CTRL, 4'h3);
    wr(ADDR_OSC_CTRL, 4'h0);
    wr(ADDR_HANDSFREE, 4'hf);
    wr(ADDR_OUT_SELECT, 4'hf);
    check(20'(line.port_out[3]), 20'h1);
    rd(ADDR_OUT_SELECT, 4'hc);
    rd(ADDR_HANDSFREE, 4'h8);
    wr(ADDR_OUT_SELECT, 4'h0);
    wr(ADDR_HANDSFREE, 4'h0);
    wr(8'hf0, 4'hf);
    rd(8'hf0, 4'h0);
    $display("register access done");
  endtask : t_regs

  task automatic t_flash();
    int n;
    int bad;
    wr(ADDR_HOOK_CTRL, 4'h1);
    rd(ADDR_HOOK_CTRL, 4'h1);
    wr(ADDR_IRQ_MASK, 4'h1);
    wr(ADDR_FLASH_SEL, 4'h1);
    wr(ADDR_LINE_CTRL, 4'h1);
    n = 0;
    while (line.dial_pulse_out_n !== 1'b0 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(20'({line.receive_silence_n, line.transmit_silence_n}), 20'h0);
    n = 0;
    while (line.dial_pulse_out_n === 1'b0 && n < 8000) begin
      @(posedge clk);
      #1;
      n++;
    end
    near(n, 3072 * DIV, 3 * DIV);
    n = 0;
    bad = 0;
    while (irq !== 1'b1 && n < 70000) begin
      if (line.receive_silence_n !== 1'b0 || line.transmit_silence_n !== 1'b0) begin
        bad++;
      end
      @(posedge clk);
      #1;
      n++;
    end
    near(n, 30720 * DIV, 3 * DIV);
    check(20'(bad), 20'h0);
    rd(ADDR_LINE_CTRL, 4'h0);
    check(20'({line.dial_pulse_out_n, line.receive_silence_n}), 20'h3);
    wr(ADDR_IRQ_MASK, 4'h0);
    check(20'(irq), 20'h0);
    wr(ADDR_IRQ_MASK, 4'h1);
    check(20'(irq), 20'h1);
    rd(ADDR_IRQ_FLAG, 4'h1);
    rd(ADDR_IRQ_FLAG, 4'h0);
    $display("flash cycle done");
  endtask : t_flash

  task automatic t_hold();
    wr(ADDR_OUT_SELECT, 4'h4);
    wr(ADDR_LINE_CTRL, 4'h4);
    check(20'({line.port_out[2], line.transmit_silence_n}), 20'h2);
    rd(ADDR_LINE_CTRL, 4'h4);
    wr(ADDR_LINE_CTRL, 4'h0);
    check(20'({line.port_out[2], line.transmit_silence_n}), 20'h1);
    wr(ADDR_PORT_DATA, 4'h4);
    check(20'(line.port_out[2]), 20'h1);
    wr(ADDR_PORT_DATA, 4'h0);
    wr(ADDR_OUT_SELECT, 4'h0);
    wr(ADDR_LINE_CTRL, 4'h4);
    check(20'(line.port_out[2]), 20'h0);
    wr(ADDR_LINE_CTRL, 4'h0);
    check(20'(irq), 20'h0);
    $display("hold line done");
  endtask : t_hold

  task automatic t_tone();
    int n;
    wr(ADDR_DIAL_CODE, 4'h5);
    check(20'({line.tone_active, line.transmit_silence_n}), 20'h2);
    wait_irq(n, 20000);
    near(n, (3072 + 3072) * DIV, 4 * DIV + 4);
    rd(ADDR_IRQ_FLAG, 4'h1);
    $display("tone digit done");
  endtask : t_tone

  task automatic t_pulse();
    int n;
    wr(ADDR_MODE_CFG, 4'h9);
    wr(ADDR_GAP_SEL, 4'h1);
    clear = 1'b0;
    wr(ADDR_DIAL_CODE, 4'h2);
    wait_irq(n, 20000);
    near(n, (2 * (655 + 983) + 3072) * DIV, 4 * DIV + 4);
    check(20'(pulse_count), 20'h2);
    near(int'(break_len), 983 * DIV, 2 * DIV);
    rd(ADDR_IRQ_FLAG, 4'h1);
    $display("pulse digit done");
  endtask : t_pulse

  task automatic t_pause();
    int bad;
    wr(ADDR_PAUSE_SEL, 4'h1);
    rd(ADDR_PAUSE_SEL, 4'h1);
    wr(ADDR_LINE_CTRL, 4'h2);
    // A digit written while the pause runs must not start
    wr(ADDR_DIAL_CODE, 4'h3);
    bad = 0;
    repeat (2000) begin
      if ({line.dial_pulse_out_n, irq} !== 2'h2) begin
        bad++;
      end
      @(posedge clk);
      #1;
    end
    check(20'(bad), 20'h0);
    check(20'(pulse_count), 20'h2);
    check(20'({line.receive_silence_n, line.transmit_silence_n}), 20'h3);
    rd(ADDR_LINE_CTRL, 4'h0);
    rd(ADDR_DIAL_CODE, 4'h3);
    $display("pause start done");
  endtask : t_pause

  task automatic give_verdict();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_regs();
    t_flash();
    t_hold();
    t_tone();
    t_pulse();
    t_pause();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : tb_top
